// file: rtl/dmee_cfg.svh
// constants for the dual mode serial memory slave and its master
`ifndef DMEE_CFG_SVH
`define DMEE_CFG_SVH
`define DMEE_ADDR_W 7
`define DMEE_DEPTH 128
`define DMEE_DEV_CODE 4'h0a
`define DMEE_PAGE_LOW_W 3
`define DMEE_SYNC_IDLE 9
`define DMEE_SYNC_CNT_W 4
`define DMEE_PROG_TIME_US 5
`define DMEE_CLK_MHZ 50
`define DMEE_PROG_CYCLES (`DMEE_PROG_TIME_US * `DMEE_CLK_MHZ)
`define DMEE_PROG_CNT_W 12
`define DMEE_SCL_HALF 16'h00fa
`define DMEE_DIV_W 16
`endif

// file: rtl/dmee_pkg.sv
// types shared by both ends of the serial memory link
package dmee_pkg;
  typedef enum logic [4:0] {
    DMEE_IDLE = 5'b0_0001,
    DMEE_CTRL = 5'b0_0010,
    DMEE_WADDR = 5'b0_0100,
    DMEE_WDATA = 5'b0_1000,
    DMEE_RDATA = 5'b1_0000
  } dmee_state_type;
  typedef enum logic [3:0] {
    DMEE_M_IDLE = 4'b0001,
    DMEE_M_START = 4'b0010,
    DMEE_M_BIT = 4'b0100,
    DMEE_M_STOP = 4'b1000
  } dmee_mstate_type;
endpackage : dmee_pkg

// file: rtl/dmee_if.sv
// link between the memory slave and the bus master
`timescale 1ns/1ps
`default_nettype none
interface dmee_if;
  logic scl;
  logic scl_oe;
  logic sda_dev_oe;
  logic sda_dev_out;
  logic sda_mst_oe;
  logic sda_mst_out;
  logic aux_clock_write_protect;
  logic sda;
  // open drain wire: low if any driver pulls low
  assign sda = ~((sda_dev_oe & ~sda_dev_out) | (sda_mst_oe & ~sda_mst_out));
  modport device (
    input scl, sda, aux_clock_write_protect,
    output sda_dev_oe, sda_dev_out
  );
  modport master (
    input sda,
    output scl, scl_oe, sda_mst_oe, sda_mst_out, aux_clock_write_protect
  );
endinterface : dmee_if
`default_nettype wire

// file: rtl/dmee_sync.sv
// two flip-flop synchroniser with edge detection after the second stage
`timescale 1ns/1ps
`default_nettype none
module dmee_sync (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // asynchronous level in, synchronous level and edges out
  input wire logic din,
  output logic dout,
  output logic rise,
  output logic fall
);
  logic meta;
  logic prev;
  // two stages then one delay for edges
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta <= 1'b1;
      dout <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= din;
      dout <= meta;
      prev <= dout;
    end
  end
  assign rise = dout & ~prev;
  assign fall = ~dout & prev;
endmodule : dmee_sync
`default_nettype wire

// file: rtl/dmee_device.sv
// memory end: transmit-only stream and two-wire bus slave
// What this block does
// (RULE1) no acknowledge while programming runs
// (RULE2) stop after write starts programming
// (RULE3) master polls with write control byte
// (RULE4) writes blocked while aux clock low
// (RULE5) read control byte has direction one
// (RULE6) counter holds last address plus one
// (RULE7) read control byte acked, byte sent
// (RULE8) no ack plus stop ends read
// (RULE9) random read: address, repeated start, read
// (RULE10) repeated start loads pointer, no programming
// (RULE11) master ack sends next sequential byte
// (RULE12) pointer increments after each operation
// (RULE13) data line only pulled low or released
// (RULE14) data changes only while clock low
// (RULE15) falling clock leaves transmit-only mode
// (RULE16) stream bits on aux clock rising edge
// (RULE17) nine idle aux clocks, msb on tenth
// (RULE18) control code 1010, three ignored, direction
// (RULE19) page write wraps low three bits
// (RULE20) seven bit pointer wraps to zero
`timescale 1ns/1ps
`include "dmee_cfg.svh"
`default_nettype none
module dmee_device (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link
  dmee_if.device bus,
  // user side status
  output logic bidir_mode,
  output logic prog_busy
);
  logic [7:0] mem [0:`DMEE_DEPTH-1];
  logic [7:0] page [0:(1<<`DMEE_PAGE_LOW_W)-1];
  logic [`DMEE_ADDR_W-1:0] ptr;
  logic [`DMEE_ADDR_W-1:0] page_base;
  logic [(1<<`DMEE_PAGE_LOW_W)-1:0] page_fill;
  logic [`DMEE_PROG_CNT_W-1:0] prog_cnt;
  logic [`DMEE_SYNC_CNT_W-1:0] sync_cnt;
  logic [7:0] shreg;
  logic [3:0] bitn;
  logic ack_phase;
  logic rd_dir;
  logic mst_nack;
  logic got_data;
  logic wp_ok;
  logic [2:0] tx_bit;
  dmee_pkg::dmee_state_type state;
  logic scl_s, scl_r, scl_f, sda_s, sda_r, sda_f, aux_s, aux_r, aux_f;

  // synchronise every pin input
  dmee_sync u_scl (.clk(clk), .resetn(resetn), .din(bus.scl),
    .dout(scl_s), .rise(scl_r), .fall(scl_f));
  dmee_sync u_sda (.clk(clk), .resetn(resetn), .din(bus.sda),
    .dout(sda_s), .rise(sda_r), .fall(sda_f));
  dmee_sync u_aux (.clk(clk), .resetn(resetn),
    .din(bus.aux_clock_write_protect),
    .dout(aux_s), .rise(aux_r), .fall(aux_f));

  function automatic logic [`DMEE_ADDR_W-1:0] inc_addr(
    input logic [`DMEE_ADDR_W-1:0] a);
    inc_addr = a + `DMEE_ADDR_W'(1); // [RULE20]
  endfunction : inc_addr

  logic start_c, stop_c;
  assign start_c = sda_f & scl_s; // [RULE14]
  assign stop_c = sda_r & scl_s; // [RULE14]

  // mode switch on first falling scl
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bidir_mode <= 1'b0;
    end else if (scl_f) begin
      bidir_mode <= 1'b1; // [RULE15]
    end
  end

  // programming timer; busy flag kept in a flop beside the count
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prog_cnt <= '0;
      prog_busy <= 1'b0;
    end else if (stop_c && bidir_mode && state == dmee_pkg::DMEE_WDATA &&
                 got_data && wp_ok) begin
      prog_cnt <= `DMEE_PROG_CNT_W'(`DMEE_PROG_CYCLES); // [RULE2]
      prog_busy <= 1'b1;
    end else if (prog_cnt != '0) begin
      prog_cnt <= prog_cnt - `DMEE_PROG_CNT_W'(1);
      prog_busy <= (prog_cnt != `DMEE_PROG_CNT_W'(1));
    end
  end

  // commit the page buffer on stop; array reads as all zeros after reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < `DMEE_DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (stop_c && bidir_mode && state == dmee_pkg::DMEE_WDATA &&
                 got_data && wp_ok) begin
      for (int i = 0; i < (1<<`DMEE_PAGE_LOW_W); i++) begin
        if (page_fill[i]) begin
          mem[{page_base[`DMEE_ADDR_W-1:`DMEE_PAGE_LOW_W],
               `DMEE_PAGE_LOW_W'(i)}] <= page[i]; // [RULE19]
        end
      end
    end
  end

  // bus slave state machine
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= dmee_pkg::DMEE_IDLE;
      bitn <= '0;
      ack_phase <= 1'b0;
      shreg <= '0;
      rd_dir <= 1'b0;
      ptr <= '0;
      page_base <= '0;
      page_fill <= '0;
      got_data <= 1'b0;
      mst_nack <= 1'b0;
      wp_ok <= 1'b0;
    end else if (!bidir_mode) begin
      state <= dmee_pkg::DMEE_IDLE;
    end else if (start_c) begin
      state <= dmee_pkg::DMEE_CTRL; // [RULE10]
      bitn <= '0;
      ack_phase <= 1'b0;
      got_data <= 1'b0;
      page_fill <= '0;
    end else if (stop_c) begin
      state <= dmee_pkg::DMEE_IDLE; // [RULE8]
      ack_phase <= 1'b0;
    end else if (scl_r && !ack_phase && state != dmee_pkg::DMEE_IDLE) begin
      if (state != dmee_pkg::DMEE_RDATA) begin
        shreg <= {shreg[6:0], sda_s};
      end
      bitn <= bitn + 4'h1;
    end else if (scl_r && ack_phase && state == dmee_pkg::DMEE_RDATA) begin
      mst_nack <= sda_s; // [RULE8]
    end else if (scl_f && state != dmee_pkg::DMEE_IDLE) begin
      if (!ack_phase && bitn == 4'h8) begin
        ack_phase <= 1'b1;
        bitn <= '0;
        unique case (state)
          dmee_pkg::DMEE_CTRL: begin
            if (shreg[7:4] != `DMEE_DEV_CODE || prog_busy) begin // [RULE18]
              state <= dmee_pkg::DMEE_IDLE; // [RULE1] [RULE3]
            end else begin
              rd_dir <= shreg[0]; // [RULE5]
              if (shreg[0]) begin
                shreg <= mem[ptr]; // [RULE6] [RULE7]
                ptr <= inc_addr(ptr); // [RULE12]
              end
            end
          end
          dmee_pkg::DMEE_WADDR: begin
            ptr <= shreg[`DMEE_ADDR_W-1:0]; // [RULE10]
            page_base <= shreg[`DMEE_ADDR_W-1:0];
            wp_ok <= aux_s; // [RULE4]
          end
          dmee_pkg::DMEE_WDATA: begin
            page[ptr[`DMEE_PAGE_LOW_W-1:0]] <= shreg;
            page_fill[ptr[`DMEE_PAGE_LOW_W-1:0]] <= 1'b1;
            got_data <= 1'b1;
            wp_ok <= wp_ok & aux_s; // [RULE4]
            ptr <= {ptr[`DMEE_ADDR_W-1:`DMEE_PAGE_LOW_W],
                    ptr[`DMEE_PAGE_LOW_W-1:0] +
                    `DMEE_PAGE_LOW_W'(1)}; // [RULE19]
          end
          dmee_pkg::DMEE_RDATA: begin
          end
          default: begin
          end
        endcase
      end else if (ack_phase) begin
        ack_phase <= 1'b0;
        unique case (state)
          dmee_pkg::DMEE_CTRL: begin
            state <= rd_dir ? dmee_pkg::DMEE_RDATA : dmee_pkg::DMEE_WADDR;
          end
          dmee_pkg::DMEE_WADDR: begin
            state <= dmee_pkg::DMEE_WDATA;
          end
          dmee_pkg::DMEE_WDATA: begin
            state <= dmee_pkg::DMEE_WDATA;
          end
          dmee_pkg::DMEE_RDATA: begin
            if (mst_nack) begin
              state <= dmee_pkg::DMEE_IDLE; // [RULE8]
            end else begin
              shreg <= mem[ptr]; // [RULE11]
              ptr <= inc_addr(ptr); // [RULE12] [RULE20]
            end
          end
          default: begin
          end
        endcase
      end else if (state == dmee_pkg::DMEE_RDATA) begin
        shreg <= {shreg[6:0], 1'b1};
      end
    end
  end

  // transmit-only stream: idle sync, then bits on aux rising edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync_cnt <= '0;
      tx_bit <= '0;
    end else if (!bidir_mode && aux_r) begin
      if (sync_cnt != `DMEE_SYNC_CNT_W'(`DMEE_SYNC_IDLE)) begin
        sync_cnt <= sync_cnt + `DMEE_SYNC_CNT_W'(1); // [RULE17]
      end else begin
        tx_bit <= tx_bit + 3'h1; // [RULE16]
      end
    end
  end

  logic stream_bit;

  // stream address advances after each whole byte
  logic [`DMEE_ADDR_W-1:0] saddr;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      saddr <= '0;
    end else if (!bidir_mode && aux_r && tx_bit == 3'h7 &&
                 sync_cnt == `DMEE_SYNC_CNT_W'(`DMEE_SYNC_IDLE)) begin
      saddr <= inc_addr(saddr); // [RULE12]
    end
  end
  assign stream_bit = mem[saddr][3'h7 - tx_bit];

  // open drain output: drive only low, change on falling scl, or on aux rise in the stream
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus.sda_dev_out <= 1'b0; // [RULE13]
      bus.sda_dev_oe <= 1'b0;
    end else if (!bidir_mode) begin
      if (scl_f) begin
        bus.sda_dev_oe <= 1'b0; // [RULE15] let go when leaving the stream
      end else if (aux_r &&
                   sync_cnt == `DMEE_SYNC_CNT_W'(`DMEE_SYNC_IDLE)) begin
        bus.sda_dev_oe <= ~stream_bit; // [RULE16] [RULE17] [RULE13]
      end else if (sync_cnt != `DMEE_SYNC_CNT_W'(`DMEE_SYNC_IDLE)) begin
        bus.sda_dev_oe <= 1'b0;
      end
    end else if (start_c || stop_c) begin
      bus.sda_dev_oe <= 1'b0;
    end else if (scl_f) begin // [RULE14]
      if (!ack_phase && bitn == 4'h8 && state == dmee_pkg::DMEE_CTRL) begin
        bus.sda_dev_oe <= (shreg[7:4] == `DMEE_DEV_CODE) & ~prog_busy;
      end else if (!ack_phase && bitn == 4'h8 &&
                   state != dmee_pkg::DMEE_RDATA &&
                   state != dmee_pkg::DMEE_IDLE) begin
        bus.sda_dev_oe <= ~prog_busy; // [RULE1]
      end else if (ack_phase && state == dmee_pkg::DMEE_CTRL && rd_dir) begin
        bus.sda_dev_oe <= ~shreg[7]; // [RULE7]
      end else if (ack_phase && state == dmee_pkg::DMEE_RDATA) begin
        bus.sda_dev_oe <= ~mst_nack & ~mem[ptr][7]; // [RULE11]
      end else if (!ack_phase && state == dmee_pkg::DMEE_RDATA &&
                   bitn != 4'h8) begin
        bus.sda_dev_oe <= ~shreg[6];
      end else begin
        bus.sda_dev_oe <= 1'b0; // [RULE8]
      end
    end
  end
  logic unused_ok;
  assign unused_ok = aux_f;
endmodule : dmee_device
`default_nettype wire

// file: rtl/dmee_master.sv
// bus master end: drives scl, start, stop and byte transfers
`timescale 1ns/1ps
`include "dmee_cfg.svh"
`default_nettype none
module dmee_master (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link
  dmee_if.master bus,
  // user command: one byte transfer
  input wire logic cmd_valid,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic cmd_ack,
  input wire logic [7:0] cmd_data,
  input wire logic write_enable,
  output logic cmd_ready,
  // result
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_acked
);
  dmee_pkg::dmee_mstate_type state;
  logic [`DMEE_DIV_W-1:0] div;
  logic phase;
  logic [3:0] bitn;
  logic [8:0] sh;
  logic do_stop, rd, sda_s, sda_r, sda_f;
  logic tick;
  assign tick = (div == `DMEE_SCL_HALF);

  dmee_sync u_sda (.clk(clk), .resetn(resetn), .din(bus.sda),
    .dout(sda_s), .rise(sda_r), .fall(sda_f));

  // scl divider
  always_ff @(posedge clk) begin
    if (!resetn || tick || state == dmee_pkg::DMEE_M_IDLE) begin
      div <= '0;
    end else begin
      div <= div + `DMEE_DIV_W'(1);
    end
  end

  // byte engine: optional start, nine clocks per byte, optional stop
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= dmee_pkg::DMEE_M_IDLE;
      bus.scl <= 1'b1;
      bus.scl_oe <= 1'b1;
      bus.sda_mst_oe <= 1'b0;
      bus.sda_mst_out <= 1'b0;
      bus.aux_clock_write_protect <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_acked <= 1'b0;
      phase <= 1'b0;
      bitn <= '0;
      sh <= '0;
      do_stop <= 1'b0;
      rd <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      bus.aux_clock_write_protect <= write_enable; // [RULE4]
      unique case (state)
        dmee_pkg::DMEE_M_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            do_stop <= cmd_stop;
            rd <= cmd_read; // [RULE9]
            sh <= cmd_read ? {8'hff, ~cmd_ack} : {cmd_data, 1'b1}; // [RULE5]
            bitn <= '0;
            phase <= 1'b0;
            state <= cmd_start ? dmee_pkg::DMEE_M_START
                               : dmee_pkg::DMEE_M_BIT;
          end
        end
        dmee_pkg::DMEE_M_START: begin
          // scl low, release sda, scl high, then sda low: also a repeat
          if (tick) begin
            bitn <= bitn + 4'h1;
            if (bitn == 4'h0) begin
              bus.scl <= 1'b0;
              bus.sda_mst_oe <= 1'b0;
            end else if (bitn == 4'h1) begin
              bus.scl <= 1'b1;
            end else begin
              bus.sda_mst_oe <= 1'b1; // start: sda low while scl high
              bitn <= '0;
              state <= dmee_pkg::DMEE_M_BIT;
            end
          end
        end
        dmee_pkg::DMEE_M_BIT: begin
          if (tick) begin
            phase <= ~phase;
            if (!phase) begin
              bus.scl <= 1'b0;
              bus.sda_mst_oe <= ~sh[8]; // [RULE14]
            end else begin
              bus.scl <= 1'b1;
              sh <= {sh[7:0], sda_s};
              bitn <= bitn + 4'h1;
              if (bitn == 4'h8) begin
                rsp_valid <= 1'b1;
                bitn <= '0;
                rsp_data <= rd ? sh[7:0] : cmd_data;
                rsp_acked <= ~sda_s; // [RULE3] [RULE8]
                state <= do_stop ? dmee_pkg::DMEE_M_STOP
                                 : dmee_pkg::DMEE_M_IDLE;
              end
            end
          end
        end
        dmee_pkg::DMEE_M_STOP: begin
          // scl low with sda low, scl high, then release sda
          if (tick) begin
            bitn <= bitn + 4'h1;
            if (bitn == 4'h0) begin
              bus.scl <= 1'b0;
              bus.sda_mst_oe <= 1'b1;
            end else if (bitn == 4'h1) begin
              bus.scl <= 1'b1;
            end else begin
              bus.sda_mst_oe <= 1'b0; // stop condition
              do_stop <= 1'b0;
              bitn <= '0;
              state <= dmee_pkg::DMEE_M_IDLE;
            end
          end
        end
        default: begin
          state <= dmee_pkg::DMEE_M_IDLE;
        end
      endcase
    end
  end
  logic unused_ok;
  assign unused_ok = sda_r ^ sda_f;
endmodule : dmee_master
`default_nettype wire

// file: verif/dmee_link_monitor.sv
// checker on the link between the memory end and the master end
`timescale 1ns/1ps
`default_nettype none
module dmee_link_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe,
  input wire logic sda_dev_out,
  input wire logic aux_clock_write_protect,
  // memory end status
  input wire logic bidir_mode,
  input wire logic prog_busy
);
  logic [3:0] aux_rises;
  logic aux_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ==========================================
  // helper: saturating count of raw aux rises
  always_ff @(posedge clk) begin
    aux_q <= aux_clock_write_protect;
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      aux_rises <= 4'h0;
    end else if (aux_clock_write_protect && !aux_q && aux_rises != 4'hf) begin
      aux_rises <= aux_rises + 4'h1;
    end
  end
  // ==========================================
  // programming steps: busy for a while, then done in bounded time
  sequence busy_run;
    prog_busy [*8];
  endsequence
  sequence busy_over;
    ##[0:400] !prog_busy;
  endsequence
  no_drive_high_a: assert property (sda_dev_oe |-> !sda_dev_out)
    else $error("memory end drives data line high");
  busy_no_ack_a: assert property (prog_busy |-> !sda_dev_oe)
    else $error("memory end pulls data line while programming");
  busy_at_stop_a: assert property ($rose(prog_busy) |-> scl && sda)
    else $error("programming started outside a stop");
  busy_ends_a: assert property ($rose(prog_busy) |-> busy_run ##1 busy_over)
    else $error("programming length out of range");
  bidir_sticky_a: assert property (bidir_mode |=> bidir_mode)
    else $error("left bidirectional mode");
  bidir_entry_a: assert property (
    !bidir_mode && $fell(scl) |-> ##[1:4] bidir_mode)
    else $error("clock fall did not enter bidirectional mode");
  data_stable_a: assert property (
    bidir_mode && $changed(sda_dev_oe) |-> !scl)
    else $error("data line changed while clock high");
  stream_idle_a: assert property (
    !bidir_mode && aux_rises <= 4'h9 |-> !sda_dev_oe)
    else $error("stream drove data before tenth aux rise");
  stream_edge_a: assert property (
    !bidir_mode && $changed(sda_dev_oe) |-> $past(aux_clock_write_protect, 2))
    else $error("stream bit changed away from aux rise");
endmodule : dmee_link_monitor
`default_nettype wire

// file: verif/dual_mode_eeprom_serial_slave_tb_top.sv
// testbench: both link ends, stream start and bus traffic
`timescale 1ns/1ps
`default_nettype none
module dual_mode_eeprom_serial_slave_tb_top;
  typedef struct {logic [7:0] d; bit cd; logic a;} dmee_note_type;
  logic clk, resetn, cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_ack;
  logic write_enable, cmd_ready, rsp_valid, rsp_acked, bidir_mode, prog_busy;
  logic [7:0] cmd_data, rsp_data;
  logic [7:0] model [128];
  bit known [128];
  dmee_note_type notes [$];
  dmee_note_type nt;
  int errors, checks_done, rsp_seen;
  logic [31:0] seed;
  dmee_if link ();
  dmee_device i_dmee_device (.clk(clk), .resetn(resetn), .bus(link),
    .bidir_mode(bidir_mode), .prog_busy(prog_busy));
  dmee_master i_dmee_master (.clk(clk), .resetn(resetn), .bus(link),
    .cmd_valid(cmd_valid), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
    .cmd_read(cmd_read), .cmd_ack(cmd_ack), .cmd_data(cmd_data),
    .write_enable(write_enable), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_acked(rsp_acked));
  dmee_link_monitor i_dmee_link_monitor (.clk(clk), .resetn(resetn),
    .scl(link.scl), .sda(link.sda), .sda_dev_oe(link.sda_dev_oe),
    .sda_dev_out(link.sda_dev_out), .bidir_mode(bidir_mode),
    .aux_clock_write_protect(link.aux_clock_write_protect),
    .prog_busy(prog_busy));
  // ==========================================
  // clock, watchdog and helpers
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #2600us;
    errors++;
    print_verdict();
  end
  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  function logic [7:0] ctrl(input bit r);
    logic [7:0] x;
    x = rnd();
    return {4'ha, x[2:0], r};
  endfunction : ctrl
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task print_verdict();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // ==========================================
  // one byte transfer; the expected answer is noted first
  task xfer(input bit st, sp, rd, ak, input logic [7:0] d,
    input logic [7:0] ed, input bit cd, input logic ea);
    int n0, k;
    n0 = rsp_seen;
    notes.push_back('{ed, cd, ea});
    @(negedge clk);
    {cmd_start, cmd_stop, cmd_read, cmd_ack} = {st, sp, rd, ak};
    cmd_data = d;
    cmd_valid = 1'b1;
    k = 0;
    do @(posedge clk); while (cmd_ready !== 1'b1 && ++k < 2000);
    if (cmd_ready !== 1'b1)
      errors++;
    @(negedge clk);
    cmd_valid = 1'b0;
    k = 0;
    while (rsp_seen == n0 && k < 10000) begin
      @(posedge clk);
      k++;
    end
    if (rsp_seen == n0)
      errors++;
  endtask : xfer
  task wr(input logic [6:0] a, input int n);
    logic [7:0] d;
    logic [6:0] p;
    xfer(1, 0, 0, 0, ctrl(0), 8'h00, 0, 1);
    xfer(0, 0, 0, 0, {1'b0, a}, 8'h00, 0, 1);
    for (int i = 0; i < n; i++) begin
      d = rnd();
      p = {a[6:3], a[2:0] + 3'(i)};
      xfer(0, i == n - 1, 0, 0, d, 8'h00, 0, 1);
      if (write_enable) begin
        model[p] = d;
        known[p] = 1'b1;
      end
    end
  endtask : wr
  task rd(input bit ra, input logic [6:0] a, input int n);
    logic [6:0] p;
    if (ra) begin
      xfer(1, 0, 0, 0, ctrl(0), 8'h00, 0, 1);
      xfer(0, 0, 0, 0, {1'b0, a}, 8'h00, 0, 1);
    end
    xfer(1, 0, 0, 0, ctrl(1), 8'h00, 0, 1);
    for (int i = 0; i < n; i++) begin
      p = a + 7'(i);
      xfer(0, i == n - 1, 1, i != n - 1, 8'h00, model[p], known[p],
        i != n - 1);
    end
  endtask : rd
  // ==========================================
  // watcher: compares each answer with the oldest note
  always @(posedge clk) begin
    if (rsp_valid === 1'b1) begin
      nt = notes.pop_front();
      check({7'h00, rsp_acked}, {7'h00, nt.a});
      if (nt.cd)
        check(rsp_data, nt.d);
      rsp_seen++;
    end
  end
  // ==========================================
  // main sequence
  initial begin
    {resetn, cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_ack} = 6'h00;
    cmd_data = 8'h00;
    write_enable = 1'b0;
    seed = 32'h26d2_065e;
    for (int i = 0; i < 128; i++) begin
      model[i] = 8'h00;
      known[i] = 1'b1;
    end
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    // transmit-only start: line released during nine aux clocks
    for (int i = 0; i < 11; i++) begin
      write_enable = 1'b1;
      repeat (4) @(negedge clk);
      write_enable = 1'b0;
      repeat (4) @(negedge clk);
      check({7'h00, link.sda}, {7'h00, i < 9});
    end
    check({7'h00, bidir_mode}, 8'h00);
    write_enable = 1'b1;
    wr(7'h7f, 2);
    xfer(1, 1, 0, 0, ctrl(0), 8'h00, 0, 1);
    check({7'h00, bidir_mode}, 8'h01);
    write_enable = 1'b0;
    wr(7'h78, 1);
    repeat (600) @(negedge clk);
    write_enable = 1'b1;
    rd(1, 7'h78, 1);
    rd(1, 7'h7e, 1);
    rd(0, 7'h7f, 2);
    xfer(1, 1, 0, 0, 8'h52, 8'h00, 0, 0);
    print_verdict();
  end
endmodule : dual_mode_eeprom_serial_slave_tb_top
`default_nettype wire
